// ### core/acd_cfg_if.sv
// interface carrying chop configuration and results between modules
`default_nettype none
interface acd_cfg_if;
	logic        run;
	logic [3:0]  dly_sel;
	logic [2:0]  osr_sel;
	logic        restart;
	logic        result_stb;
	logic        first_done;
	logic        polarity;
	logic        filt_reset;
	modport ctl (output run, dly_sel, osr_sel, restart, input result_stb, first_done,
		polarity, filt_reset);
	modport seq (input run, dly_sel, osr_sel, restart, output result_stb, first_done,
		polarity, filt_reset);
endinterface
`default_nettype wire

// ### core/acd_chop_seq.sv
// global-chop conversion sequencer timed in modulator ticks
`default_nettype none
module acd_chop_seq (
	input  wire logic aclk,    // system clock
	input  wire logic aresetn, // sync reset, active low
	input  wire logic mod_tick, // one modulator period
	input  wire logic signed [23:0] conv_in, // raw conversion result
	output logic signed [23:0] chop_out, // averaged result
	acd_cfg_if.seq    cfg      // control
);
	acd_pkg::acd_chop_e st_ff;
	logic [17:0] cnt_ff;
	logic [1:0]  nconv_ff;
	logic [1:0]  pairs_ff;
	logic signed [23:0] prev_ff;
	logic [17:0] dly_len;
	logic [17:0] conv_len;
	logic signed [24:0] sum;

	assign dly_len  = 18'h00002 << cfg.dly_sel;
	assign conv_len = 18'(acd_pkg::OSR_BASE) << cfg.osr_sel;
	assign sum      = 25'(prev_ff) - 25'(conv_in);

	always_ff @(posedge aclk)
	begin
		cfg.result_stb <= 1'b0;
		cfg.filt_reset <= 1'b0;
		if (!aresetn || !cfg.run || cfg.restart)
		begin
			st_ff <= acd_pkg::acd_delay;
			cnt_ff <= 18'h00001;
			nconv_ff <= '0;
			pairs_ff <= '0;
			cfg.polarity <= 1'b0;
			// falling back to normal polarity is a swap too
			cfg.filt_reset <= aresetn && cfg.polarity;
			cfg.first_done <= 1'b0;
			prev_ff <= '0;
			chop_out <= '0;
		end
		else if (mod_tick)
		begin
			cnt_ff <= cnt_ff + 18'h00001;
			case (st_ff)
			acd_pkg::acd_delay:
				if (cnt_ff + 18'h00001 >= dly_len + (pairs_ff == 2'h1 ?
					18'(acd_pkg::FIRST_EXTRA_MOD) : 18'h00000))
				begin
					st_ff <= acd_pkg::acd_conv;
					cnt_ff <= '0;
				end
			acd_pkg::acd_conv:
				if (cnt_ff + 18'h00001 >= conv_len)
				begin
					cnt_ff <= '0;
					nconv_ff <= nconv_ff + 2'h1;
					if (nconv_ff == 2'(acd_pkg::CONV_PER_RESULT - 1))
						st_ff <= acd_pkg::acd_swap;
				end
			acd_pkg::acd_swap:
			begin
				st_ff <= acd_pkg::acd_delay;
				cnt_ff <= 18'h00001;
				nconv_ff <= '0;
				cfg.polarity <= ~cfg.polarity;
				cfg.filt_reset <= 1'b1;
				prev_ff <= conv_in;
				if (pairs_ff != 2'h2)
					pairs_ff <= pairs_ff + 2'h1;
				if (pairs_ff != 2'h0)
				begin
					// sliding average; negated sample of opposite polarity cancels offset
					chop_out <= cfg.polarity ? 24'(sum >>> 1) : 24'((-sum) >>> 1);
					cfg.result_stb <= 1'b1;
					cfg.first_done <= 1'b1;
				end
			end
			default: st_ff <= acd_pkg::acd_delay;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### core/acd_detect.sv
// current-detect threshold comparator and counter per channel
`default_nettype none
module acd_detect #(
	parameter int unsigned NCH = 6 // channel count
) (
	input  wire logic aclk,    // system clock
	input  wire logic aresetn, // sync reset, active low
	input  wire logic start,   // begin a pass
	input  wire logic smp_stb, // one sample on all channels
	input  wire logic [NCH*24-1:0] smp, // samples, not visible to host
	input  wire logic [23:0] thr, // threshold
	input  wire logic [2:0] len_sel, // pass length
	input  wire logic [2:0] cnt_sel, // hits required
	input  wire logic all_ch,  // all channels required
	input  wire logic [NCH-1:0] ch_en, // channel enables
	output logic      done,    // pass finished pulse
	output logic      hit      // criteria met with done
);
	logic [11:0] nsmp_ff;
	logic        busy_ff;
	logic [NCH-1:0] met;
	logic [11:0] total;
	assign total = (len_sel == 3'h0) ? 12'(acd_pkg::DET_LEN_UNIT) :
		12'(acd_pkg::DET_LEN_UNIT * acd_pkg::DET_LEN_SCALE) * 12'(len_sel);

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			logic [11:0] hits_ff;
			logic signed [23:0] s;
			logic [23:0] mag;
			assign s = smp[g*24 +: 24];
			assign mag = s[23] ? 24'(-s) : 24'(s);
			always_ff @(posedge aclk)
				if (!aresetn || start)
					hits_ff <= '0;
				else if (busy_ff && smp_stb && mag > thr && hits_ff != 12'hFFF)
					hits_ff <= hits_ff + 12'h001;
			assign met[g] = hits_ff >= 12'(cnt_sel) + 12'h001;
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		done <= 1'b0;
		hit <= 1'b0;
		if (!aresetn)
		begin
			busy_ff <= 1'b0;
			nsmp_ff <= '0;
		end
		else if (start)
		begin
			busy_ff <= 1'b1;
			nsmp_ff <= '0;
		end
		else if (busy_ff && smp_stb)
		begin
			nsmp_ff <= nsmp_ff + 12'h001;
			if (nsmp_ff + 12'h001 >= total)
			begin
				busy_ff <= 1'b0;
				done <= 1'b1;
				hit <= (ch_en != '0) && (all_ch ? ((met & ch_en) == ch_en)
					: ((met & ch_en) != '0));
			end
		end
	end
endmodule
`default_nettype wire

// ### core/acd_pkg.sv
// package with constants for chop, standby and current-detect sequencing
`default_nettype none
package acd_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned NUM_CH = 6;
	// register byte offsets
	localparam logic [7:0] OFF_CHOP_CFG = 8'h00;
	localparam logic [7:0] OFF_CLOCK_CFG = 8'h04;
	localparam logic [7:0] OFF_DETECT_CFG = 8'h08;
	localparam logic [7:0] OFF_THR_UPPER = 8'h0C;
	localparam logic [7:0] OFF_THR_LOWER = 8'h10;
	localparam logic [7:0] OFF_COMMAND = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_CONFIG = 8'h1C;
	localparam logic [7:0] OFF_CD_SAMPLE = 8'h20;
	// command codes
	localparam logic [15:0] CMD_STANDBY = 16'h0022;
	localparam logic [15:0] CMD_WAKEUP = 16'h0033;
	// field positions
	localparam int unsigned F_CHOP_EN = 0;
	localparam int unsigned F_CHOP_DLY = 4;
	localparam int unsigned F_OSR = 8;
	localparam int unsigned F_PWR = 0;
	localparam int unsigned F_CHEN = 8;
	localparam int unsigned F_DET_EN = 0;
	localparam int unsigned F_DET_ALL = 1;
	localparam int unsigned F_DET_LEN = 4;
	localparam int unsigned F_DET_CNT = 8;
	localparam int unsigned F_DC_TEST = 0;
	localparam int unsigned F_PHASE_CAL = 1;
	// reset values
	localparam logic [3:0] RST_CHOP_DLY = 4'h0;
	localparam logic [2:0] RST_OSR = 3'h3;
	localparam logic [1:0] RST_PWR = 2'h2;
	localparam logic [5:0] RST_CHEN = 6'h3F;
	// timing in modulator periods; detect pass length in detect samples
	localparam int unsigned WAKE_SETTLE_MOD = 8;
	localparam int unsigned FIRST_EXTRA_MOD = 44;
	localparam int unsigned CONV_PER_RESULT = 3;
	localparam int unsigned DET_LEN_UNIT = 128;
	localparam int unsigned DET_LEN_SCALE = 4;
	localparam int unsigned OSR_BASE = 128;
	// nominal current-detect rate in samples per second
	localparam int unsigned DET_RATE_SPS = 2700;
	localparam int unsigned DET_SAMPLE_CYC = (CLK_MHZ * 1000000) / DET_RATE_SPS;
	typedef enum logic [1:0] {acd_active, acd_standby, acd_detect} acd_mode_e;
	typedef enum logic [2:0] {acd_idle, acd_delay, acd_conv, acd_swap} acd_chop_e;
endpackage
`default_nettype wire

// ### core/acd_top.sv
// top: register slave, power mode control, global chop and current detect
`default_nettype none
module acd_top #(
	parameter int unsigned RST_PULSE_LIMIT = 4096 // cycles below which a sync pulse is short
) (
	input  wire logic aclk,          // 200 MHz clock
	input  wire logic aresetn,       // sync reset, active low
	input  wire logic [7:0] s_axi_awaddr, // write address
	input  wire logic s_axi_awvalid, // write address valid
	output logic      s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata, // write data
	input  wire logic [3:0] s_axi_wstrb, // write strobes
	input  wire logic s_axi_wvalid,  // write data valid
	output logic      s_axi_wready,  // write data ready
	output logic [1:0] s_axi_bresp,  // write response
	output logic      s_axi_bvalid,  // write response valid
	input  wire logic s_axi_bready,  // write response ready
	input  wire logic [7:0] s_axi_araddr, // read address
	input  wire logic s_axi_arvalid, // read address valid
	output logic      s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp,  // read response
	output logic      s_axi_rvalid,  // read data valid
	input  wire logic s_axi_rready,  // read data ready
	input  wire logic ext_clock_in,  // modulator clock, sampled
	input  wire logic sync_reset_n,  // sync/reset pin
	input  wire logic osc_tick,      // internal oscillator sample tick
	input  wire logic signed [23:0] conv_data, // modulator conversion result
	input  wire logic [143:0] detect_samples, // detect-mode samples
	output logic      data_ready_n,  // data ready, active low
	output logic      chop_polarity, // input polarity swap
	output logic      filter_reset,  // digital filter reset pulse
	output logic      analog_power_on, // nonessential circuitry enabled
	output logic      modulator_run, // modulators sampling
	output logic      osc_enable,    // internal oscillator enabled
	output logic      high_resolution_mode, // power mode outputs
	output logic      low_power_mode,
	output logic      very_low_power_mode,
	output logic      phase_cal_active, // phase calibration active
	output logic      dc_test_active // dc test signal routed
);
	// ************************
	// registers and state
	// ************************
	logic        chop_enable_ff;
	logic [3:0]  chop_delay_sel_ff;
	logic [2:0]  oversampling_ratio_ff;
	logic [1:0]  power_mode_sel_ff;
	logic [5:0]  channel_enable_ff;
	logic        detect_enable_ff;
	logic        detect_all_channels_ff;
	logic [2:0]  detect_length_ff;
	logic [2:0]  detect_count_ff;
	logic [11:0] threshold_upper_reg_ff;
	logic [11:0] threshold_lower_reg_ff;
	logic        dc_test_req_ff;
	logic        phase_cal_req_ff;
	acd_pkg::acd_mode_e mode_ff;
	logic [3:0]  wake_cnt_ff;
	logic        clk_d_ff;
	logic        sync_d_ff;
	logic [15:0] low_cnt_ff;
	logic        restart_ff;
	logic        awtaken_ff;
	logic        wtaken_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        wr_go;
	logic        mod_tick;
	logic        sync_fall;
	logic        sync_rise_short;
	logic        cmd_standby;
	logic        cmd_wakeup;
	logic        det_done;
	logic        det_hit;
	logic        det_start;
	logic [23:0] detect_threshold;
	logic signed [23:0] chop_result;
	acd_cfg_if   cfg ();

	assign detect_threshold = {threshold_upper_reg_ff, threshold_lower_reg_ff};
	assign mod_tick = ext_clock_in && !clk_d_ff && mode_ff == acd_pkg::acd_active;
	assign sync_fall = !sync_reset_n && sync_d_ff;
	assign sync_rise_short = sync_reset_n && !sync_d_ff &&
		low_cnt_ff < 16'(RST_PULSE_LIMIT);

	// ************************
	// axi4-lite write
	// ************************
	assign s_axi_awready = !awtaken_ff && !s_axi_bvalid;
	assign s_axi_wready  = !wtaken_ff && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign wr_go = awtaken_ff && wtaken_ff && !s_axi_bvalid;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			awtaken_ff <= 1'b0;
			awaddr_ff <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awtaken_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		else if (wr_go)
			awtaken_ff <= 1'b0;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			wtaken_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wtaken_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		else if (wr_go)
			wtaken_ff <= 1'b0;

	always_ff @(posedge aclk)
		if (!aresetn)
			s_axi_bvalid <= 1'b0;
		else if (wr_go)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;

	// register writes; all settings survive standby
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			chop_enable_ff <= 1'b0;
			chop_delay_sel_ff <= acd_pkg::RST_CHOP_DLY;
			oversampling_ratio_ff <= acd_pkg::RST_OSR;
			power_mode_sel_ff <= acd_pkg::RST_PWR;
			channel_enable_ff <= acd_pkg::RST_CHEN;
			detect_enable_ff <= 1'b0;
			detect_all_channels_ff <= 1'b0;
			detect_length_ff <= '0;
			detect_count_ff <= '0;
			threshold_upper_reg_ff <= '0;
			threshold_lower_reg_ff <= '0;
			dc_test_req_ff <= 1'b0;
			phase_cal_req_ff <= 1'b0;
		end
		else if (wr_go)
			case (awaddr_ff)
			acd_pkg::OFF_CHOP_CFG:
			begin
				if (wstrb_ff[0])
				begin
					chop_enable_ff <= wdata_ff[acd_pkg::F_CHOP_EN];
					chop_delay_sel_ff <= wdata_ff[acd_pkg::F_CHOP_DLY +: 4];
				end
				if (wstrb_ff[1])
					oversampling_ratio_ff <= wdata_ff[acd_pkg::F_OSR +: 3];
			end
			acd_pkg::OFF_CLOCK_CFG:
			begin
				if (wstrb_ff[0])
					power_mode_sel_ff <= wdata_ff[acd_pkg::F_PWR +: 2];
				if (wstrb_ff[1])
					channel_enable_ff <= wdata_ff[acd_pkg::F_CHEN +: 6];
			end
			acd_pkg::OFF_DETECT_CFG:
			begin
				if (wstrb_ff[0])
				begin
					detect_enable_ff <= wdata_ff[acd_pkg::F_DET_EN];
					detect_all_channels_ff <= wdata_ff[acd_pkg::F_DET_ALL];
					detect_length_ff <= wdata_ff[acd_pkg::F_DET_LEN +: 3];
				end
				if (wstrb_ff[1])
					detect_count_ff <= wdata_ff[acd_pkg::F_DET_CNT +: 3];
			end
			acd_pkg::OFF_THR_UPPER:
				if (wstrb_ff[0] && wstrb_ff[1])
					threshold_upper_reg_ff <= wdata_ff[11:0];
			acd_pkg::OFF_THR_LOWER:
				if (wstrb_ff[0] && wstrb_ff[1])
					threshold_lower_reg_ff <= wdata_ff[11:0];
			acd_pkg::OFF_CONFIG:
				if (wstrb_ff[0])
				begin
					dc_test_req_ff <= wdata_ff[acd_pkg::F_DC_TEST];
					phase_cal_req_ff <= wdata_ff[acd_pkg::F_PHASE_CAL];
				end
			default: ;
			endcase

	assign cmd_standby = wr_go && awaddr_ff == acd_pkg::OFF_COMMAND &&
		wdata_ff[15:0] == acd_pkg::CMD_STANDBY;
	assign cmd_wakeup = wr_go && awaddr_ff == acd_pkg::OFF_COMMAND &&
		wdata_ff[15:0] == acd_pkg::CMD_WAKEUP;

	// ************************
	// axi4-lite read
	// ************************
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'h0;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
			acd_pkg::OFF_CHOP_CFG: s_axi_rdata <= 32'({oversampling_ratio_ff,
				chop_delay_sel_ff, 3'h0, chop_enable_ff});
			acd_pkg::OFF_CLOCK_CFG: s_axi_rdata <= 32'({channel_enable_ff, 6'h00,
				power_mode_sel_ff});
			acd_pkg::OFF_DETECT_CFG: s_axi_rdata <= 32'({detect_count_ff, 1'b0,
				detect_length_ff, 2'h0, detect_all_channels_ff, detect_enable_ff});
			acd_pkg::OFF_THR_UPPER: s_axi_rdata <= 32'(threshold_upper_reg_ff);
			acd_pkg::OFF_THR_LOWER: s_axi_rdata <= 32'(threshold_lower_reg_ff);
			acd_pkg::OFF_STATUS: s_axi_rdata <= 32'({cfg.first_done, cfg.polarity,
				mode_ff});
			acd_pkg::OFF_CONFIG: s_axi_rdata <= 32'({phase_cal_req_ff, dc_test_req_ff});
			// the chop result is readable; detect samples never are
			acd_pkg::OFF_CD_SAMPLE: s_axi_rdata <= 32'(chop_result);
			default: s_axi_rdata <= '0;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;

	// ************************
	// pin sampling and sync pulse width
	// ************************
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			clk_d_ff <= 1'b0;
			sync_d_ff <= 1'b1;
		end
		else
		begin
			clk_d_ff <= ext_clock_in;
			sync_d_ff <= sync_reset_n;
		end

	always_ff @(posedge aclk)
		if (!aresetn || sync_fall)
			low_cnt_ff <= '0;
		else if (!sync_reset_n && low_cnt_ff != 16'hFFFF)
			low_cnt_ff <= low_cnt_ff + 16'h0001;

	// ************************
	// power mode state
	// ************************
	assign det_start = mode_ff == acd_pkg::acd_standby && sync_rise_short &&
		detect_enable_ff;

	always_ff @(posedge aclk)
		if (!aresetn)
			mode_ff <= acd_pkg::acd_active;
		else
			case (mode_ff)
			acd_pkg::acd_active:
				if (cmd_standby)
					mode_ff <= acd_pkg::acd_standby;
			acd_pkg::acd_standby:
				if (cmd_wakeup)
					mode_ff <= acd_pkg::acd_active;
				else if (det_start)
					mode_ff <= acd_pkg::acd_detect;
			acd_pkg::acd_detect:
				if (det_done || !detect_enable_ff)
					mode_ff <= acd_pkg::acd_standby;
			default: mode_ff <= acd_pkg::acd_active;
			endcase

	// modulators start after eight modulator clock rising edges once awake
	always_ff @(posedge aclk)
		if (!aresetn || mode_ff != acd_pkg::acd_active)
			wake_cnt_ff <= '0;
		else if (mod_tick && wake_cnt_ff != 4'(acd_pkg::WAKE_SETTLE_MOD))
			wake_cnt_ff <= wake_cnt_ff + 4'h1;

	assign modulator_run = wake_cnt_ff == 4'(acd_pkg::WAKE_SETTLE_MOD) &&
		channel_enable_ff != '0;
	assign analog_power_on = mode_ff == acd_pkg::acd_active;
	assign osc_enable = mode_ff == acd_pkg::acd_detect;
	assign high_resolution_mode = power_mode_sel_ff == 2'h2 ||
		power_mode_sel_ff == 2'h3;
	assign low_power_mode = power_mode_sel_ff == 2'h1;
	assign very_low_power_mode = power_mode_sel_ff == 2'h0;
	assign phase_cal_active = phase_cal_req_ff && !chop_enable_ff;
	assign dc_test_active = dc_test_req_ff && !chop_enable_ff;

	// ************************
	// global chop
	// ************************
	always_ff @(posedge aclk)
		if (!aresetn)
			restart_ff <= 1'b0;
		else
			restart_ff <= sync_fall || (wr_go && awaddr_ff == acd_pkg::OFF_CHOP_CFG &&
				wstrb_ff[1] && wdata_ff[acd_pkg::F_OSR +: 3] != oversampling_ratio_ff);

	assign cfg.run = chop_enable_ff && modulator_run;
	assign cfg.dly_sel = chop_delay_sel_ff;
	assign cfg.osr_sel = oversampling_ratio_ff;
	assign cfg.restart = restart_ff;
	assign chop_polarity = cfg.polarity;
	assign filter_reset = cfg.filt_reset;

	acd_chop_seq u_chop (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.mod_tick (mod_tick),
		.conv_in  (conv_data),
		.chop_out (chop_result),
		.cfg      (cfg)
	);

	// ************************
	// current detect
	// ************************
	acd_detect #(.NCH(acd_pkg::NUM_CH)) u_det (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (det_start),
		.smp_stb  (osc_tick && mode_ff == acd_pkg::acd_detect),
		.smp      (detect_samples),
		.thr      (detect_threshold),
		.len_sel  (detect_length_ff),
		.cnt_sel  (detect_count_ff),
		.all_ch   (detect_all_channels_ff),
		.ch_en    (channel_enable_ff),
		.done     (det_done),
		.hit      (det_hit)
	);

	// data-ready: one-cycle low pulse per event
	always_ff @(posedge aclk)
		if (!aresetn)
			data_ready_n <= 1'b1;
		else
			data_ready_n <= !(cfg.result_stb || (det_done && det_hit));
endmodule
`default_nettype wire

// ### tb/acd_checker.sv
// assertion checker for the chop, standby and detect outputs
`default_nettype none
module acd_checker #(
	parameter int unsigned RST_PULSE_LIMIT = 4096 // short sync limit
) (
	input wire logic        aclk,                 // clk
	input wire logic        aresetn,              // rst
	input wire logic [7:0]  s_axi_awaddr,         // aw
	input wire logic        s_axi_awvalid,        // aw
	input wire logic        s_axi_awready,        // aw
	input wire logic [31:0] s_axi_wdata,          // w
	input wire logic        s_axi_wvalid,         // w
	input wire logic        s_axi_wready,         // w
	input wire logic        data_ready_n,         // pin
	input wire logic        chop_polarity,        // pin
	input wire logic        filter_reset,         // pin
	input wire logic        analog_power_on,      // pin
	input wire logic        modulator_run,        // pin
	input wire logic        osc_enable,           // pin
	input wire logic        high_resolution_mode, // pin
	input wire logic        low_power_mode,       // pin
	input wire logic        very_low_power_mode,  // pin
	input wire logic        phase_cal_active,     // pin
	input wire logic        dc_test_active        // pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic wr_fire;
	logic chop_on_ff;
	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// shadow of the chop enable bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			chop_on_ff <= 1'b0;
		else if (wr_fire && s_axi_awaddr == acd_pkg::OFF_CHOP_CFG)
			chop_on_ff <= s_axi_wdata[acd_pkg::F_CHOP_EN];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_cmd_wr(logic [15:0] code);
		wr_fire && s_axi_awaddr == acd_pkg::OFF_COMMAND && s_axi_wdata[15:0] == code;
	endsequence
	// ****
	// assertions
	// ****
	a_data_ready_n_pulse: assert property (!data_ready_n |=> data_ready_n)
		else $error("data ready low too long");
	a_swap_filt_rst: assert property (
		$changed(chop_polarity) |-> filter_reset || $past(filter_reset))
		else $error("swap without filter reset");
	a_phase_cal_off: assert property (chop_on_ff && $past(chop_on_ff) |-> !phase_cal_active)
		else $error("phase cal on in chop");
	a_dc_test_off: assert property (chop_on_ff && $past(chop_on_ff) |-> !dc_test_active)
		else $error("dc test on in chop");
	a_power_onehot: assert property (
		$onehot({high_resolution_mode, low_power_mode, very_low_power_mode}))
		else $error("power mode not one-hot");
	a_standby_off: assert property (
		s_cmd_wr(acd_pkg::CMD_STANDBY) |-> ##[1:3] !analog_power_on && !modulator_run)
		else $error("standby left power on");
	a_wake_settle: assert property (
		s_cmd_wr(acd_pkg::CMD_WAKEUP) ##0 !modulator_run |=> !modulator_run [*8])
		else $error("modulator ran early");
	a_detect_exit: assert property (
		!data_ready_n && $past(osc_enable) |-> ##[0:4] !osc_enable)
		else $error("detect did not return");
endmodule
bind acd_top acd_checker #(.RST_PULSE_LIMIT(RST_PULSE_LIMIT)) u_chk (.*);
`default_nettype wire

// ### tb/acd_host_model.sv
// host model driving the external modulator clock pin
`default_nettype none
module acd_host_model (
	input  wire logic aclk,               // system clock
	input  wire logic run,                // clock wanted
	output var logic  ext_clock_in = 1'b0 // modulator clock pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// clock stands still low in standby and detect
	// ****
	always @(posedge aclk)
		ext_clock_in <= run ? !ext_clock_in : 1'b0;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for acd_top
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [4:0] f;} acd_row_s;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_run, sync_reset_n;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_tick;
	logic ext_clock_in, data_ready_n, chop_polarity, filter_reset, analog_power_on;
	logic modulator_run, osc_enable, phase_cal_active, dc_test_active;
	logic high_resolution_mode, low_power_mode, very_low_power_mode;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic [143:0] detect_samples;
	logic [4:0]   flags;
	int           err_total, checked, cyc, n_rdy, t0, t1, t2;
	acd_row_s     rows [7];
	assign flags = {high_resolution_mode, low_power_mode, very_low_power_mode,
		phase_cal_active, dc_test_active};
	acd_top #(.RST_PULSE_LIMIT(20)) u_dut (.s_axi_wstrb(4'hF), .s_axi_bready(1'b1),
		.s_axi_rready(1'b1), .conv_data(24'h000400), .*);
	acd_host_model u_host (.aclk, .run(ext_run), .ext_clock_in);
	// ****
	// clock, timeout and tasks
	// ****
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	always @(negedge aclk)
		if (data_ready_n === 1'b0)
			n_rdy++;
	task automatic tally_and_finish;
		$display("mismatches %0d, checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, hit;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw)
		begin
			@(negedge aclk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do begin @(negedge aclk); hit = s_axi_bvalid; @(posedge aclk); end while (!hit);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		logic hit;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin @(negedge aclk); hit = s_axi_arready; @(posedge aclk); end while (!hit);
		s_axi_arvalid <= 1'b0;
		do begin @(negedge aclk); hit = s_axi_rvalid; d = s_axi_rdata; @(posedge aclk); end while (!hit);
	endtask
	task automatic wait_data_ready_n(output int t);
		@(posedge aclk);
		do @(negedge aclk); while (data_ready_n !== 1'b0);
		t = cyc;
		@(posedge aclk);
	endtask
	task automatic pulse_sync(input int n);
		@(posedge aclk);
		sync_reset_n <= 1'b0;
		repeat (n) @(posedge aclk);
		sync_reset_n <= 1'b1;
	endtask
	task automatic run_ticks(input int n);
		repeat (n)
		begin
			@(posedge aclk);
			osc_tick <= 1'b1;
			@(posedge aclk);
			osc_tick <= 1'b0;
		end
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, osc_tick, ext_run} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, detect_samples} = '0;
		sync_reset_n = 1'b1;
		rows = '{'{8'h04, 32'h3F00, 32'h3F00, 5'h04}, '{8'h04, 32'h3F01, 32'h3F01, 5'h08},
			'{8'h04, 32'h3F03, 32'h3F03, 5'h10}, '{8'h0C, 32'hABC, 32'hABC, 5'h10},
			'{8'h10, 32'h100, 32'h100, 5'h10}, '{8'h30, 32'h55, 32'h0, 5'h10},
			'{8'h1C, 32'h3, 32'h3, 5'h13}};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		ext_run <= 1'b1;
		@(posedge aclk);
		chk(data_ready_n, 1);
		axi_rd(8'h04, rd);
		chk(rd, 32'h3F02);
		foreach (rows[i])
		begin
			axi_wr(rows[i].a, rows[i].d);
			axi_rd(rows[i].a, rd);
			chk(rd, rows[i].q);
			chk(flags, rows[i].f);
		end
		axi_wr(8'h00, 32'h001);
		chk(flags[1:0], 0);
		pulse_sync(2);
		t0 = cyc;
		wait_data_ready_n(t1);
		chk(t1 - t0 > 1631 && t1 - t0 < 1635, 1);
		wait_data_ready_n(t2);
		chk(t2 - t1, 772);
		axi_rd(8'h20, rd);
		chk(rd, 0);
		chk({s_axi_bresp, s_axi_rresp, chop_polarity}, 5'h01);
		chk(osc_enable, 0);
		axi_wr(8'h14, 32'h0022);
		ext_run <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({analog_power_on, modulator_run}, 0);
		axi_rd(8'h00, rd);
		chk(rd, 32'h001);
		axi_wr(8'h08, 32'h001);
		axi_wr(8'h0C, 32'h000);
		detect_samples <= {{5{24'h000010}}, 24'hFFFE00};
		pulse_sync(3);
		@(posedge aclk);
		@(negedge aclk);
		chk(osc_enable, 1);
		t0 = n_rdy;
		run_ticks(130);
		chk(n_rdy - t0, 1);
		chk(osc_enable, 0);
		axi_wr(8'h08, 32'h003);
		pulse_sync(3);
		t0 = n_rdy;
		run_ticks(127);
		chk(osc_enable, 1);
		run_ticks(3);
		chk(n_rdy - t0, 0);
		chk(osc_enable, 0);
		axi_wr(8'h14, 32'h0033);
		ext_run <= 1'b1;
		t0 = cyc;
		do @(negedge aclk); while (modulator_run !== 1'b1);
		chk(cyc - t0 >= 15 && cyc - t0 <= 26, 1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
